// file: logic/t1pec_pkg.sv
// Package of constants and types for the T1 performance error counters
package t1pec_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_LCV_HI   = 8'h50;
    localparam logic [7:0] IDX_LCV_LO   = 8'h51;
    localparam logic [7:0] IDX_PCV_HI   = 8'h52;
    localparam logic [7:0] IDX_PCV_LO   = 8'h53;
    localparam logic [7:0] IDX_SYNC_HI  = 8'h54;
    localparam logic [7:0] IDX_SYNC_LO  = 8'h55;
    localparam logic [7:0] IDX_CONFIG   = 8'h86;
    localparam logic [7:0] IDX_LINECFG  = 8'h87;

    localparam int         ADDR_W       = 12;

    // error_counter_config fields
    localparam int BIT_COUNT_EXCESS_ZEROS   = 0;
    localparam int BIT_SYNC_FUNC_SELECT     = 1;
    localparam int BIT_SIG_FRAME_ERR_EN     = 2;
    localparam int BIT_ACCUM_MODE_SELECT    = 3;
    localparam int BIT_UPDATE_INTERVAL_SEL  = 4;
    localparam int BIT_MANUAL_UPDATE_TRIG   = 5;
    localparam int BIT_MANUAL_SOURCE_SEL    = 6;
    localparam int BIT_ONE_SECOND_SRC_SEL   = 7;
    localparam logic [7:0] CONFIG_RESET     = 8'h00;

    // line_config fields
    localparam int BIT_E1_MODE              = 0;
    localparam int BIT_B8ZS_ENABLE          = 1;
    localparam int BIT_ESF_MODE             = 2;
    localparam int BIT_GLOBAL_LATCH         = 3;
    localparam logic [7:0] LINECFG_RESET    = 8'h00;

    localparam logic [15:0] COUNT_RESET     = 16'h0000;

    // Timing
    localparam longint CLK_HZ               = 50_000_000;
    localparam longint ONE_SECOND_MS        = 1000;
    localparam longint ONE_SECOND_CYCLES    = CLK_HZ / 1000 * ONE_SECOND_MS;
    localparam int     SHORT_T1_FRAMES      = 336;
    localparam int     SHORT_E1_FRAMES      = 500;
    localparam int     ZERO_RUN_PLAIN       = 16;
    localparam int     ZERO_RUN_B8ZS        = 8;
    localparam int     MANUAL_WAIT_US       = 250;

    localparam logic [1:0] RESP_OKAY        = 2'b00;
    localparam logic [1:0] RESP_SLVERR      = 2'b10;

    // Decoded events from the receive framer, one clock each except the receiveSyncLost level and the bitIsZero value
    typedef struct packed {
        logic bitValid;
        logic bitIsZero;
        logic bipolarViolation;
        logic inB8zsCodeword;
        logic frameTick;
        logic multiframeEnd;
        logic ftError;
        logic fsError;
        logic crcError;
        logic fpsError;
        logic receiveSyncLost;
    } t1pec_events_t;

endpackage

// file: logic/t1pec_counters.sv
// T1 performance error counters with AXI4-Lite register access
// Summary of operation
// (RULE1) T1: interval bit 0 latches each second, 1 latches every 336 frames.
// (RULE2) E1: interval bit 0 latches each second, 1 latches every 500 frames.
// (RULE3) Manual mode: rising manual trigger bit latches counts and clears counters in the same cycle.
// (RULE4) Host waits at least 250 us after a manual update before reading counts.
// (RULE5) Manual source select picks local trigger bit or the global latch bit.
// (RULE6) One-second source select picks own timer or the first framer's second.
// (RULE7) Line counter counts bipolar violations, optionally excess zeros; B8ZS codewords excluded.
// (RULE8) Line counter keeps counting during loss of synchronization.
// (RULE9) Excess zeros mean 16 zeros without B8ZS, 8 zeros with B8ZS.
// (RULE10) Line count is 16 bits: high byte at index 50h, low at 51h.
// (RULE11) Path counter counts CRC6 errors in ESF, terminal framing errors in D4.
// (RULE12) D4 with signalling error enable also counts signalling framing errors.
// (RULE13) Path counter stops during loss of synchronization.
// (RULE14) Path count is 16 bits in two bytes; low byte at index 53h.
// (RULE15) Sync count mode: one count per multiframe spent out of sync, always.
// (RULE16) Framing-bit mode: count Ft errors in D4, FRAMING_PATTERN_SEQUENCE errors in ESF; not while lost.
// (RULE17) Sync count is 16 bits: high byte at index 54h, low at 55h.
// (RULE18) Line counter saturates; path and sync counters wrap.
// (RULE19) Accumulation mode 0 is timed update, 1 is manual update.
// (RULE20) Timed latch also copies counts and restarts counters in the same cycle.
// (RULE21) Latched bytes stay stable between latch events.
`timescale 1ns/1ps
`default_nettype none

module t1pec_counters
    import t1pec_pkg::*;
#(
    parameter longint SECOND_CYCLES = ONE_SECOND_CYCLES
) (
    // Clock, reset, enable
    input  wire logic                clk,
    input  wire logic                arst_n,
    input  wire logic                ce,
    // Receive framer events and shared one-second reference
    input  wire t1pec_events_t       events,
    input  wire logic                firstFramerSecond,
    // AXI4-Lite write address and data
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    // AXI4-Lite write response
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    output logic [1:0]               s_axi_bresp,
    // AXI4-Lite read
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    input  wire logic [ADDR_W-1:0]   s_axi_araddr,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    output logic [31:0]              s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    // Own one-second tick, for sharing with other framers
    output logic                     oneSecondTick
);

    logic [7:0]  errorCounterConfig;
    logic [7:0]  lineConfig;
    logic [15:0] lineCodeErrCount;
    logic [15:0] pathErrCount;
    logic [15:0] syncLossCount;
    logic [15:0] lineCodeErrRun;
    logic [15:0] pathErrRun;
    logic [15:0] syncLossRun;
    logic [31:0] secondCounter;
    logic [8:0]  frameCounter;
    logic [4:0]  zeroRun;
    logic        manualTrigPrev;
    logic        globalLatchPrev;
    logic        manualEdge;
    logic        latchNow;
    logic        oosSeen;

    // Configuration field aliases
    logic        countExcessZeros;
    logic        syncCountFunctionSelect;
    logic        signallingFrameErrorEnable;
    logic        accumulationModeSelect;
    logic        updateIntervalSelect;
    logic        manualSourceSelect;
    logic        oneSecondSourceSelect;
    logic        e1Mode;
    logic        b8zsEnable;
    logic        esfMode;
    logic        globalLatchBit;

    assign countExcessZeros           = errorCounterConfig[BIT_COUNT_EXCESS_ZEROS];
    assign syncCountFunctionSelect    = errorCounterConfig[BIT_SYNC_FUNC_SELECT];
    assign signallingFrameErrorEnable = errorCounterConfig[BIT_SIG_FRAME_ERR_EN];
    assign accumulationModeSelect     = errorCounterConfig[BIT_ACCUM_MODE_SELECT];
    assign updateIntervalSelect       = errorCounterConfig[BIT_UPDATE_INTERVAL_SEL];
    assign manualSourceSelect         = errorCounterConfig[BIT_MANUAL_SOURCE_SEL];
    assign oneSecondSourceSelect      = errorCounterConfig[BIT_ONE_SECOND_SRC_SEL];
    assign e1Mode                     = lineConfig[BIT_E1_MODE];
    assign b8zsEnable                 = lineConfig[BIT_B8ZS_ENABLE];
    assign esfMode                    = lineConfig[BIT_ESF_MODE];
    assign globalLatchBit             = lineConfig[BIT_GLOBAL_LATCH];

    // AXI4-Lite slave
    logic        writeFire;
    logic        readFire;
    logic [7:0]  writeIndex;
    logic [7:0]  readIndex;
    logic [7:0]  readByte;
    logic        readHit;

    assign writeFire     = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
    assign s_axi_awready = writeFire;
    assign s_axi_wready  = writeFire;
    assign readFire      = s_axi_arvalid && !s_axi_rvalid;
    assign s_axi_arready = readFire;
    assign writeIndex    = s_axi_awaddr[9:2];
    assign readIndex     = s_axi_araddr[9:2];

    always_comb begin
        readHit  = 1'b1;
        readByte = 8'h00;
        case (readIndex)
            IDX_LCV_HI:  readByte = lineCodeErrCount[15:8];   // [RULE10]
            IDX_LCV_LO:  readByte = lineCodeErrCount[7:0];    // [RULE10]
            IDX_PCV_HI:  readByte = pathErrCount[15:8];       // [RULE14]
            IDX_PCV_LO:  readByte = pathErrCount[7:0];        // [RULE14]
            IDX_SYNC_HI: readByte = syncLossCount[15:8];      // [RULE17]
            IDX_SYNC_LO: readByte = syncLossCount[7:0];       // [RULE17]
            IDX_CONFIG:  readByte = errorCounterConfig;
            IDX_LINECFG: readByte = lineConfig;
            default:     readHit  = 1'b0;
        endcase
        if (s_axi_araddr[ADDR_W-1:10] != '0 || s_axi_araddr[1:0] != 2'b00) begin
            readHit = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (ce) begin
            if (writeFire) begin
                s_axi_bvalid <= 1'b1;
                if (s_axi_awaddr[ADDR_W-1:10] == '0 && s_axi_awaddr[1:0] == 2'b00
                    && (writeIndex == IDX_CONFIG || writeIndex == IDX_LINECFG
                        || (writeIndex >= IDX_LCV_HI && writeIndex <= IDX_SYNC_LO))) begin
                    s_axi_bresp <= RESP_OKAY;
                end else begin
                    s_axi_bresp <= RESP_SLVERR;
                end
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= RESP_OKAY;
        end else if (ce) begin
            if (readFire) begin
                s_axi_rvalid <= 1'b1;
                // Refused reads return zero data
                s_axi_rdata  <= readHit ? {24'h000000, readByte} : 32'h00000000;
                s_axi_rresp  <= readHit ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Configuration registers; count registers ignore writes
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            errorCounterConfig <= CONFIG_RESET;
            lineConfig         <= LINECFG_RESET;
        end else if (ce) begin
            if (writeFire && s_axi_wstrb[0] && s_axi_awaddr[ADDR_W-1:10] == '0
                && s_axi_awaddr[1:0] == 2'b00) begin
                if (writeIndex == IDX_CONFIG) begin
                    errorCounterConfig <= s_axi_wdata[7:0];
                end
                if (writeIndex == IDX_LINECFG) begin
                    lineConfig <= s_axi_wdata[7:0];
                end
            end
        end
    end

    // Latch timing
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            secondCounter <= 32'h00000000;
            oneSecondTick <= 1'b0;
        end else if (ce) begin
            if (secondCounter >= 32'(SECOND_CYCLES - 1)) begin
                secondCounter <= 32'h00000000;
                oneSecondTick <= 1'b1;
            end else begin
                secondCounter <= secondCounter + 32'h00000001;
                oneSecondTick <= 1'b0;
            end
        end
    end

    // Short interval counted in received frames
    logic        frameIntervalDone;
    logic [8:0]  frameLimit;

    assign frameLimit = e1Mode ? 9'(SHORT_E1_FRAMES - 1) : 9'(SHORT_T1_FRAMES - 1);
    assign frameIntervalDone = events.frameTick && frameCounter >= frameLimit; // [RULE1] [RULE2]

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            frameCounter <= 9'h000;
        end else if (ce) begin
            if (frameIntervalDone) begin
                frameCounter <= 9'h000;
            end else if (events.frameTick) begin
                frameCounter <= frameCounter + 9'h001;
            end
        end
    end

    // Rising edges of the selected manual trigger
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            manualTrigPrev  <= 1'b0;
            globalLatchPrev <= 1'b0;
            manualEdge      <= 1'b0;
        end else if (ce) begin
            manualTrigPrev  <= errorCounterConfig[BIT_MANUAL_UPDATE_TRIG];
            globalLatchPrev <= globalLatchBit;
            manualEdge      <= manualSourceSelect                                  // [RULE5]
                ? (globalLatchBit && !globalLatchPrev)
                : (errorCounterConfig[BIT_MANUAL_UPDATE_TRIG] && !manualTrigPrev); // [RULE3]
        end
    end

    logic secondRef;

    assign secondRef = oneSecondSourceSelect ? firstFramerSecond : oneSecondTick; // [RULE6]

    always_comb begin
        if (accumulationModeSelect) begin                                  // [RULE19]
            latchNow = manualEdge;                                         // [RULE3]
        end else if (updateIntervalSelect) begin
            latchNow = frameIntervalDone;                                  // [RULE1] [RULE2]
        end else begin
            latchNow = secondRef;                                          // [RULE1] [RULE2]
        end
    end

    // Event qualification
    logic [4:0]  zeroLimit;
    logic        excessZeroHit;
    logic        lineEvent;
    logic        pathEvent;
    logic        syncEvent;

    assign zeroLimit = b8zsEnable ? 5'(ZERO_RUN_B8ZS) : 5'(ZERO_RUN_PLAIN); // [RULE9]
    assign excessZeroHit = events.bitValid && events.bitIsZero
                           && (zeroRun == zeroLimit - 5'd1);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            zeroRun <= 5'd0;
        end else if (ce) begin
            if (events.bitValid) begin
                if (!events.bitIsZero || excessZeroHit) begin
                    zeroRun <= 5'd0;
                end else begin
                    zeroRun <= zeroRun + 5'd1;
                end
            end
        end
    end

    // Line events count regardless of sync state
    assign lineEvent = (events.bipolarViolation
                        && !(b8zsEnable && events.inB8zsCodeword))          // [RULE7] [RULE8]
                       || (countExcessZeros && excessZeroHit);              // [RULE9]

    assign pathEvent = !events.receiveSyncLost                             // [RULE13]
        && (esfMode ? events.crcError                                      // [RULE11]
                    : (events.ftError
                       || (signallingFrameErrorEnable && events.fsError))); // [RULE12]

    // Multiframe out-of-sync tracking
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            oosSeen <= 1'b0;
        end else if (ce) begin
            if (events.multiframeEnd) begin
                oosSeen <= 1'b0;
            end else if (events.receiveSyncLost) begin
                oosSeen <= 1'b1;
            end
        end
    end

    assign syncEvent = syncCountFunctionSelect
        ? (events.multiframeEnd && (oosSeen || events.receiveSyncLost))    // [RULE15]
        : (!events.receiveSyncLost
           && (esfMode ? events.fpsError : events.ftError));               // [RULE16]

    // Running counters and latched copies
    logic [15:0] next_lineRun;
    logic [15:0] next_pathRun;
    logic [15:0] next_syncRun;

    always_comb begin
        next_lineRun = lineCodeErrRun;
        if (lineEvent && lineCodeErrRun != 16'hffff) begin                 // [RULE18]
            next_lineRun = lineCodeErrRun + 16'h0001;
        end
        next_pathRun = pathErrRun + {15'h0000, pathEvent};                 // [RULE18]
        next_syncRun = syncLossRun + {15'h0000, syncEvent};                // [RULE18]
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            lineCodeErrRun <= COUNT_RESET;
            pathErrRun     <= COUNT_RESET;
            syncLossRun    <= COUNT_RESET;
        end else if (ce) begin
            if (latchNow) begin                                            // [RULE20]
                lineCodeErrRun <= {15'h0000, lineEvent};
                pathErrRun     <= {15'h0000, pathEvent};
                syncLossRun    <= {15'h0000, syncEvent};
            end else begin
                lineCodeErrRun <= next_lineRun;
                pathErrRun     <= next_pathRun;
                syncLossRun    <= next_syncRun;
            end
        end
    end

    // Readable copies change only on a latch event
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            lineCodeErrCount <= COUNT_RESET;
            pathErrCount     <= COUNT_RESET;
            syncLossCount    <= COUNT_RESET;
        end else if (ce) begin
            if (latchNow) begin                                            // [RULE21] [RULE3]
                lineCodeErrCount <= lineCodeErrRun;
                pathErrCount     <= pathErrRun;
                syncLossCount    <= syncLossRun;
            end
        end
    end

endmodule

`default_nettype wire

// file: testbench/t1pec_framer_model.sv
// Receive framer model producing decoded line events on command
`timescale 1ns/1ps
`default_nettype none
module t1pec_framer_model
    import t1pec_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       arst_n,
    // Commands from the bench
    input  wire logic       go,
    input  wire logic [3:0] kind,
    input  wire logic       syncLost,
    // Decoded events
    output var t1pec_events_t events
);
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            events <= '0;
        end else begin
            events <= '0;
            // Bit value flips while no bit is valid
            events.bitIsZero <= ~events.bitIsZero;
            events.receiveSyncLost <= syncLost;
            if (go) begin
                case (kind)
                    4'h0: events.bipolarViolation <= 1'b1;
                    4'h1: {events.bipolarViolation, events.inB8zsCodeword} <= 2'b11;
                    4'h2: {events.bitValid, events.bitIsZero} <= 2'b11;
                    4'h3: {events.bitValid, events.bitIsZero} <= 2'b10;
                    4'h4: events.frameTick <= 1'b1;
                    4'h5: events.multiframeEnd <= 1'b1;
                    4'h6: events.ftError <= 1'b1;
                    4'h7: events.fsError <= 1'b1;
                    4'h8: events.crcError <= 1'b1;
                    4'h9: events.fpsError <= 1'b1;
                    default: ;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// file: testbench/t1pec_checker_assertions.sv
// Port-level assertions for the T1 performance error counters
`timescale 1ns/1ps
`default_nettype none
module t1pec_checker
    import t1pec_pkg::*;
#(
    parameter longint SECOND_CYCLES = ONE_SECOND_CYCLES
) (
    // Clock and reset
    input wire logic              clk,
    input wire logic              arst_n,
    input wire logic              ce,
    // Register bus
    input wire logic              s_axi_awvalid,
    input wire logic              s_axi_awready,
    input wire logic              s_axi_wvalid,
    input wire logic              s_axi_wready,
    input wire logic              s_axi_bvalid,
    input wire logic              s_axi_bready,
    input wire logic [1:0]        s_axi_bresp,
    input wire logic              s_axi_arvalid,
    input wire logic              s_axi_arready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic              s_axi_rvalid,
    input wire logic              s_axi_rready,
    input wire logic [31:0]       s_axi_rdata,
    input wire logic [1:0]        s_axi_rresp,
    // Own one-second tick
    input wire logic              oneSecondTick
);
    longint gap;
    logic   seenTick;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    // Cycles since the last own tick
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            gap <= 0;
            seenTick <= 1'b0;
        end else if (oneSecondTick) begin
            gap <= 0;
            seenTick <= 1'b1;
        end else begin
            gap <= gap + 1;
        end
    end

    wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready && ce |=> s_axi_bvalid) else $error("write not answered");
    b_hold_a: assert property (s_axi_bvalid && !(s_axi_bready && ce)
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
    b_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while busy");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready && ce |=> s_axi_rvalid)
        else $error("read not answered");
    r_hold_a: assert property (s_axi_rvalid && !(s_axi_rready && ce) |=> s_axi_rvalid
        && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read data moved");
    byte_wide_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("read data too wide");
    bad_addr_a: assert property (s_axi_arvalid && s_axi_arready && ce
        && (s_axi_araddr >= 12'h400 || s_axi_araddr[1:0] != 2'b00)
        |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0) else $error("bad read taken");
    count_map_a: assert property (s_axi_arvalid && s_axi_arready && ce
        && s_axi_araddr[ADDR_W-1:2] inside {[10'h050:10'h055]} && s_axi_araddr[1:0] == 2'b00
        |=> s_axi_rresp == RESP_OKAY) else $error("count register refused");
    tick_period_a: assert property (oneSecondTick && seenTick
        |-> gap == SECOND_CYCLES - 1 ##1 !oneSecondTick) else $error("own second off");
endmodule

bind t1pec_counters t1pec_checker #(.SECOND_CYCLES(SECOND_CYCLES)) i_checker (.*);
`default_nettype wire

// file: testbench/testbench.sv
// Self-checking bench for the T1 error counters
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import t1pec_pkg::*;
    localparam longint SEC  = 1000;
    localparam int     WAIT = MANUAL_WAIT_US * 50;
    logic          clk, arst_n, go, syncLost, firstSec, tick;
    logic          awv, wv, awr, wrr, bv, brdy, arv, arr, rv, rrdy;
    logic [3:0]    kind;
    logic [11:0]   awa, ara;
    logic [31:0]   wd, rdat;
    logic [1:0]    br, rr;
    logic [33:0]   e, expQ[$];
    t1pec_events_t ev;
    int            fail_count, compares, a, b, n;

    t1pec_framer_model i_fr (.clk, .arst_n, .go, .kind, .syncLost, .events(ev));
    t1pec_counters #(.SECOND_CYCLES(SEC)) i_dut (.clk, .arst_n, .ce(1'b1),
        .events(ev), .firstFramerSecond(firstSec), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(wrr), .s_axi_wdata(wd),
        .s_axi_wstrb(4'h1), .s_axi_bvalid(bv), .s_axi_bready(brdy), .s_axi_bresp(br),
        .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_rvalid(rv),
        .s_axi_rready(rrdy), .s_axi_rdata(rdat), .s_axi_rresp(rr), .oneSecondTick(tick));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic tally_and_finish();
        if (fail_count == 0 && compares > 0 && expQ.size() == 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic timeout(input bit hit);
        if (hit) begin
            fail_count++;
            tally_and_finish();
        end
    endtask

    function automatic logic [11:0] ba(input logic [7:0] idx);
        return {2'b00, idx, 2'b00};
    endfunction

    task automatic axi_wr(input logic [7:0] idx, input logic [7:0] d);
        int k;
        awa <= ba(idx);
        wd <= {24'h0, d};
        {awv, wv} <= 2'b11;
        for (k = 0; k < 200 && !(awr && wrr); k++) @(negedge clk);
        timeout(k == 200);
        @(posedge clk);
        {awv, wv} <= 2'b00;
        for (k = 0; k < 200 && bv !== 1'b1; k++) @(negedge clk);
        timeout(k == 200);
        @(posedge clk);
    endtask

    task automatic axi_rd(input logic [11:0] ad, input logic [33:0] ex);
        int k;
        expQ.push_back(ex);
        ara <= ad;
        arv <= 1'b1;
        for (k = 0; k < 200 && arr !== 1'b1; k++) @(negedge clk);
        timeout(k == 200);
        @(posedge clk);
        arv <= 1'b0;
        for (k = 0; k < 200 && rv !== 1'b1; k++) @(negedge clk);
        timeout(k == 200);
        @(posedge clk);
    endtask

    task automatic counts(input logic [15:0] l, input logic [15:0] p = 16'h0,
                          input logic [15:0] s = 16'h0);
        logic [47:0] v = {l, p, s};
        for (int i = 0; i < 6; i++) begin
            axi_rd(ba(IDX_LCV_HI + 8'(i)), {RESP_OKAY, 24'h0, v[47 - 8 * i -: 8]});
        end
    endtask

    task automatic pulse(input logic [3:0] k, input int cnt);
        kind <= k;
        go <= 1'b1;
        repeat (cnt) @(posedge clk);
        go <= 1'b0;
        @(posedge clk);
    endtask

    task automatic latch(input logic [7:0] cfg);
        axi_wr(IDX_CONFIG, cfg | 8'h20);
        repeat (WAIT) @(posedge clk);
    endtask

    task automatic tick_wait();
        int k;
        for (k = 0; k < 1100 && tick !== 1'b1; k++) @(negedge clk);
        timeout(k == 1100);
        repeat (2) @(posedge clk);
    endtask

    always @(posedge clk) begin
        if (rv === 1'b1 && rrdy === 1'b1) begin
            e = expQ.size() > 0 ? expQ.pop_front() : 34'h3ffffffff;
            compares++;
            if ({rr, rdat} !== e) begin
                fail_count++;
                $display("wrong value at %0t: got %h expected %h", $time, {rr, rdat}, e);
            end
        end
    end

    initial begin
        {arst_n, go, kind, syncLost, firstSec, awv, wv, arv} = '0;
        {brdy, rrdy} = 2'b11;
        {awa, ara, wd, fail_count, compares} = '0;
        n = $urandom(32'h322a);
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        counts(16'h0);
        axi_rd(ba(IDX_CONFIG), {RESP_OKAY, 24'h0, CONFIG_RESET});
        axi_rd(ba(8'h60), {RESP_SLVERR, 32'h0});
        axi_rd(12'h141, {RESP_SLVERR, 32'h0});
        axi_wr(IDX_LCV_LO, 8'hff);
        axi_rd(ba(IDX_LCV_LO), {RESP_OKAY, 32'h0});
        a = $urandom_range(9, 1);
        b = $urandom_range(9, 1);
        n = $urandom_range(9, 1);
        axi_wr(IDX_LINECFG, 8'h04);
        axi_wr(IDX_CONFIG, 8'h0c);
        pulse(4'h0, a);
        pulse(4'h8, n);
        pulse(4'h9, b);
        pulse(4'h7, 3);
        pulse(4'h2, 20);
        syncLost <= 1'b1;
        pulse(4'h0, 2);
        pulse(4'h8, 4);
        pulse(4'h9, 5);
        syncLost <= 1'b0;
        latch(8'h0c);
        counts(16'(a + 2), 16'(n), 16'(b));
        axi_wr(IDX_LINECFG, 8'h02);
        axi_wr(IDX_CONFIG, 8'h09);
        pulse(4'h6, a);
        pulse(4'h7, b);
        pulse(4'h1, n);
        pulse(4'h0, 3);
        pulse(4'h3, 1);
        pulse(4'h2, 7);
        pulse(4'h3, 1);
        pulse(4'h2, 8);
        pulse(4'h3, 1);
        latch(8'h09);
        counts(16'h4, 16'(a), 16'(a));
        axi_wr(IDX_LINECFG, 8'h00);
        axi_wr(IDX_CONFIG, 8'h0f);
        pulse(4'h6, a);
        pulse(4'h7, b);
        pulse(4'h2, 15);
        pulse(4'h3, 1);
        pulse(4'h2, 16);
        pulse(4'h3, 1);
        syncLost <= 1'b1;
        pulse(4'h5, n);
        pulse(4'h6, 2);
        syncLost <= 1'b0;
        latch(8'h0f);
        counts(16'h1, 16'(a + b), 16'(n));
        axi_wr(IDX_CONFIG, 8'h48);
        pulse(4'h0, b);
        latch(8'h48);
        counts(16'h1, 16'(a + b), 16'(n));
        axi_wr(IDX_LINECFG, 8'h08);
        repeat (WAIT) @(posedge clk);
        counts(16'(b));
        axi_wr(IDX_LINECFG, 8'h00);
        axi_wr(IDX_CONFIG, 8'h10);
        pulse(4'h0, a);
        pulse(4'h4, 335);
        counts(16'(b));
        pulse(4'h4, 1);
        counts(16'(a));
        axi_wr(IDX_LINECFG, 8'h01);
        pulse(4'h0, n);
        pulse(4'h4, 499);
        counts(16'(a));
        pulse(4'h4, 1);
        counts(16'(n));
        axi_wr(IDX_LINECFG, 8'h00);
        axi_wr(IDX_CONFIG, 8'h80);
        pulse(4'h0, b);
        repeat (SEC + 100) @(posedge clk);
        counts(16'(n));
        firstSec <= 1'b1;
        @(posedge clk);
        firstSec <= 1'b0;
        repeat (2) @(posedge clk);
        counts(16'(b));
        axi_wr(IDX_CONFIG, 8'h00);
        tick_wait();
        pulse(4'h0, a);
        tick_wait();
        counts(16'(a));
        @(posedge clk);
        tally_and_finish();
    end
endmodule
`default_nettype wire
